// [rtl/flash_host.v]
// Serial flash host: issues one instruction frame per command it does not refuse, over SPI mode 0
// Summary of operation
// - Opcode 03 plain read, 13 long form; clock at most 50 MHz.
// - Opcodes 0D, 0E double-rate quick read: always refused, never sent.
// - Opcodes 3B, 3C two-line output read, at most 104 MHz.
// - Opcodes 6B, 6C four-line output read, at most 104 MHz.
// - Opcode BB two-line address and data read, long companion; 104 MHz.
// - Opcodes BD, BE double-rate two-line address and data read: always refused.
// - Opcodes EB, EC four-line address and data read, at most 104 MHz.
// - Opcodes ED, EE double-rate four-line address and data read: always refused.
// - Opcodes 32, 38 four-line page program, 34 long form; 80 MHz.
// - Host never sends reserved opcodes A3, E5 or E6.
// - Read mode exit: all ones on line 0 for eight clocks.
`timescale 1ns/1ps
`include "flash_host_regs.vh"

module flash_host #(
  parameter SCK_HALF = `SCK_HALF_DEFAULT
) (
  input  wire        core_clk,
  input  wire        reset,
  input  wire        cmdValid,
  output wire        cmdReady,
  input  wire [7:0]  cmdOpcode,
  input  wire [31:0] cmdAddr,
  input  wire [2:0]  cmdAddrBytes,
  input  wire [7:0]  cmdDummy,
  input  wire [15:0] cmdWriteCount,
  input  wire [15:0] cmdReadCount,
  output reg         cmdError,
  output reg         cmdDone,
  input  wire [7:0]  txData,
  input  wire        txValid,
  output wire        txReady,
  output reg  [7:0]  rxData,
  output reg         rxValid,
  output reg         serialClock,
  output reg         chipSelectN,
  output reg  [3:0]  dataLineOut,
  output wire [3:0]  dataLineOe,
  input  wire [3:0]  dataLineIn
);

  localparam ST_IDLE  = 3'h0;
  localparam ST_OPC   = 3'h1;
  localparam ST_ADDR  = 3'h2;
  localparam ST_DUMMY = 3'h3;
  localparam ST_LOADW = 3'h4;
  localparam ST_WR    = 3'h5;
  localparam ST_RD    = 3'h6;
  localparam ST_END   = 3'h7;

  // Serial clock rate that this divider produces, in whole MHz
  localparam integer SCK_RATE = `CORE_CLK_MHZ / (2 * SCK_HALF);
  // Cut to eight bits on purpose: every rate limit fits in a byte
  localparam [7:0]   SCK_MHZ  = SCK_RATE[7:0];

  // Opcode class: [7] refuse, [6] long address only, [5:3] addr lanes, [2:0] data lanes
  function [7:0] opInfo;
    input [7:0] op;
    begin
      case (op)
        `OP_PERF_MODE, `OP_RESERVED_E5, `OP_RESERVED_E6:
          opInfo = {2'b10, `LANE1, `LANE1};
        `OP_DDR_QUICK, `OP_DDR_QUICK_L, `OP_DDR_DUAL_IO, `OP_DDR_DUAL_IO_L,
        `OP_DDR_QUAD_IO, `OP_DDR_QUAD_IO_L:
          opInfo = {2'b10, `LANE1, `LANE1};
        `OP_QUICK_READ_L, `OP_PLAIN_READ_L, `OP_PAGE_PROG_L,
        `OP_SMALL_ERASE_L, `OP_SECTOR_ERASE_L:
          opInfo = {2'b01, `LANE1, `LANE1};
        `OP_DUAL_OUT:    opInfo = {2'b00, `LANE1, `LANE2};
        `OP_DUAL_OUT_L:  opInfo = {2'b01, `LANE1, `LANE2};
        `OP_QUAD_OUT:    opInfo = {2'b00, `LANE1, `LANE4};
        `OP_QUAD_OUT_L:  opInfo = {2'b01, `LANE1, `LANE4};
        `OP_DUAL_IO:     opInfo = {2'b00, `LANE2, `LANE2};
        `OP_DUAL_IO_L:   opInfo = {2'b01, `LANE2, `LANE2};
        `OP_QUAD_IO:     opInfo = {2'b00, `LANE4, `LANE4};
        `OP_QUAD_IO_L:   opInfo = {2'b01, `LANE4, `LANE4};
        `OP_QUAD_PROG_A, `OP_QUAD_PROG_B:
          opInfo = {2'b00, `LANE1, `LANE4};
        `OP_QUAD_PROG_L: opInfo = {2'b01, `LANE1, `LANE4};
        default:         opInfo = {2'b00, `LANE1, `LANE1};
      endcase
    end
  endfunction

  // Highest serial clock rate allowed per opcode
  function [7:0] opLimit;
    input [7:0] op;
    begin
      case (op)
        `OP_PLAIN_READ, `OP_PLAIN_READ_L: opLimit = `MHZ_50;
        `OP_DDR_QUICK, `OP_DDR_QUICK_L, `OP_DDR_DUAL_IO, `OP_DDR_DUAL_IO_L,
        `OP_DDR_QUAD_IO, `OP_DDR_QUAD_IO_L:
          opLimit = `MHZ_80;
        `OP_QUAD_PROG_A, `OP_QUAD_PROG_B, `OP_QUAD_PROG_L:
          opLimit = `MHZ_80;
        `OP_DUAL_OUT, `OP_DUAL_OUT_L, `OP_QUAD_OUT, `OP_QUAD_OUT_L,
        `OP_DUAL_IO, `OP_DUAL_IO_L, `OP_QUAD_IO, `OP_QUAD_IO_L:
          opLimit = `MHZ_104;
        default: opLimit = `MHZ_133;
      endcase
    end
  endfunction

  // Drive pattern: top bits of the shifter on the active lanes, idle lines high
  function [3:0] laneOut;
    input [7:0] sh;
    input [2:0] ln;
    begin
      case (ln)
        `LANE2:  laneOut = {2'b11, sh[7:6]};
        `LANE4:  laneOut = sh[7:4];
        default: laneOut = {3'b111, sh[7]};
      endcase
    end
  endfunction

  // Frame state, serial clock divider and per-phase counters
  reg [2:0]  state;
  reg [15:0] divCnt;
  reg [7:0]  shiftOut;
  reg [7:0]  shiftIn;
  reg [3:0]  bitsLeft;
  reg [2:0]  lanes;
  reg [2:0]  addrLanes;
  reg [2:0]  dataLanes;
  reg [31:0] addrShift;
  reg [2:0]  addrLeft;
  reg [7:0]  dummyLeft;
  reg [15:0] wrLeft;
  reg [15:0] rdLeft;

  // Command class, phase decode and refusal
  wire [7:0] info     = opInfo(cmdOpcode);
  wire       active   = (state == ST_OPC) || (state == ST_ADDR) || (state == ST_DUMMY) ||
                        (state == ST_WR) || (state == ST_RD);
  wire       tick     = active && (divCnt == 16'h0000);
  wire       byteDone = (state == ST_DUMMY) ? (dummyLeft == 8'h00) : (bitsLeft == 4'h0);
  wire [7:0] shifted  = shiftOut << lanes;
  wire       refuse   = info[7] || (SCK_MHZ > opLimit(cmdOpcode));
  wire       useLong  = info[6] || (cmdAddrBytes == `ADDR_BYTES_LONG);

  // Commands taken only between frames, write bytes only in the load state
  assign cmdReady = (state == ST_IDLE);
  assign txReady  = (state == ST_LOADW) && txValid;

  // Output enables: lines turn around for multi-line reads and the gap before them
  reg [3:0] oeNext;
  always @* begin
    oeNext = 4'b0000;
    if (state == ST_OPC || state == ST_ADDR || state == ST_WR || state == ST_LOADW) begin
      oeNext = (lanes == `LANE1 && state != ST_WR) ? 4'b1101 :
               (state == ST_WR && dataLanes == `LANE1) ? 4'b1101 : 4'b1111;
    end else if (state == ST_DUMMY || state == ST_RD || state == ST_END) begin
      // Closing cycle takes the read-phase pattern, so line 0 stays driven to the end only with single-line data
      oeNext = (dataLanes == `LANE1) ? 4'hD : (dataLanes == `LANE2) ? 4'hC : 4'h0;
    end
  end
  assign dataLineOe = chipSelectN ? 4'b1101 : oeNext;

  // Frame sequencer and serial clock divider
  always @(posedge core_clk) begin
    if (reset) begin
      state       <= ST_IDLE;
      divCnt      <= 16'h0000;
      shiftOut    <= 8'h00;
      shiftIn     <= 8'h00;
      bitsLeft    <= 4'h0;
      lanes       <= `LANE1;
      addrLanes   <= `LANE1;
      dataLanes   <= `LANE1;
      addrShift   <= 32'h0000_0000;
      addrLeft    <= 3'h0;
      dummyLeft   <= 8'h00;
      wrLeft      <= 16'h0000;
      rdLeft      <= 16'h0000;
      cmdError    <= 1'b0;
      cmdDone     <= 1'b0;
      rxData      <= 8'h00;
      rxValid     <= 1'b0;
      serialClock <= 1'b0;
      chipSelectN <= 1'b1;
      dataLineOut <= 4'b1111;
    end else begin
      cmdError <= 1'b0;
      cmdDone  <= 1'b0;
      rxValid  <= 1'b0;
      if (active) begin
        divCnt <= (divCnt == 16'h0000) ? SCK_HALF[15:0] - 16'h0001 : divCnt - 16'h0001;
      end
      case (state)
        ST_IDLE: begin
          if (cmdValid) begin
            if (refuse) begin
              cmdError <= 1'b1;
            end else begin
              chipSelectN <= 1'b0;
              state       <= ST_OPC;
              divCnt      <= SCK_HALF[15:0] - 16'h0001;
              shiftOut    <= cmdOpcode;
              dataLineOut <= laneOut(cmdOpcode, `LANE1);
              lanes       <= `LANE1;
              bitsLeft    <= `BYTE_BITS;
              addrLanes   <= info[5:3];
              dataLanes   <= info[2:0];
              addrLeft    <= (cmdAddrBytes == 3'h0) ? 3'h0 :
                             (useLong ? `ADDR_BYTES_LONG : `ADDR_BYTES_SHORT);
              addrShift   <= useLong ? cmdAddr : {cmdAddr[23:0], 8'h00};
              dummyLeft   <= cmdDummy;
              wrLeft      <= cmdWriteCount;
              rdLeft      <= cmdReadCount;
            end
          end
        end
        ST_LOADW: begin
          if (txValid) begin
            shiftOut    <= txData;
            dataLineOut <= laneOut(txData, dataLanes);
            lanes       <= dataLanes;
            bitsLeft    <= `BYTE_BITS;
            wrLeft      <= wrLeft - 16'h0001;
            state       <= ST_WR;
            divCnt      <= SCK_HALF[15:0] - 16'h0001;
          end
        end
        ST_END: begin
          // Chip select rise commits register writes and resets at the device
          chipSelectN <= 1'b1;
          cmdDone     <= 1'b1;
          serialClock <= 1'b0;
          state       <= ST_IDLE;
        end
        default: begin
          if (tick && !serialClock) begin
            // Rising edge: device samples, host captures
            serialClock <= 1'b1;
            if (state == ST_DUMMY) begin
              dummyLeft <= dummyLeft - 8'h01;
            end else begin
              bitsLeft <= bitsLeft - {1'b0, lanes};
            end
            if (state == ST_RD) begin
              case (lanes)
                `LANE2:  shiftIn <= {shiftIn[5:0], dataLineIn[1:0]};
                `LANE4:  shiftIn <= {shiftIn[3:0], dataLineIn[3:0]};
                default: shiftIn <= {shiftIn[6:0], dataLineIn[1]};
              endcase
            end
          end else if (tick) begin
            // Falling edge: shift within the byte or move to the next phase
            serialClock <= 1'b0;
            if (!byteDone) begin
              shiftOut    <= shifted;
              dataLineOut <= laneOut(shifted, lanes);
            end else begin
              if (state == ST_RD) begin
                rxData  <= shiftIn;
                rxValid <= 1'b1;
              end
              if (addrLeft != 3'h0) begin
                shiftOut    <= addrShift[31:24];
                dataLineOut <= laneOut(addrShift[31:24], addrLanes);
                addrShift   <= {addrShift[23:0], 8'h00};
                addrLeft    <= addrLeft - 3'h1;
                lanes       <= addrLanes;
                bitsLeft    <= `BYTE_BITS;
                state       <= ST_ADDR;
              end else if (dummyLeft != 8'h00) begin
                lanes <= dataLanes;
                state <= ST_DUMMY;
              end else if (wrLeft != 16'h0000) begin
                state <= ST_LOADW;
              end else if (rdLeft != 16'h0000) begin
                rdLeft   <= rdLeft - 16'h0001;
                lanes    <= dataLanes;
                bitsLeft <= `BYTE_BITS;
                state    <= ST_RD;
              end else begin
                state <= ST_END;
              end
            end
          end
        end
      endcase
    end
  end

endmodule

// [rtl/flash_host_regs.vh]
// Opcode, lane and rate constants for the serial flash host controller
`ifndef FLASH_HOST_REGS_VH
`define FLASH_HOST_REGS_VH

// Core clock rate in MHz
`define CORE_CLK_MHZ        20
// Default serial clock half period in core cycles
`define SCK_HALF_DEFAULT    1

// Instruction codes
`define OP_REG_WRITE        8'h01
`define OP_PAGE_PROG        8'h02
`define OP_PLAIN_READ       8'h03
`define OP_QUICK_READ       8'h0B
`define OP_QUICK_READ_L     8'h0C
`define OP_DDR_QUICK        8'h0D
`define OP_DDR_QUICK_L      8'h0E
`define OP_PAGE_PROG_L      8'h12
`define OP_PLAIN_READ_L     8'h13
`define OP_SMALL_ERASE      8'h20
`define OP_SMALL_ERASE_L    8'h21
`define OP_STATUS_CLEAR     8'h30
`define OP_QUAD_PROG_A      8'h32
`define OP_QUAD_PROG_L      8'h34
`define OP_QUAD_PROG_B      8'h38
`define OP_DUAL_OUT         8'h3B
`define OP_DUAL_OUT_L       8'h3C
`define OP_NV_PATTERN       8'h43
`define OP_VOL_PATTERN      8'h4A
`define OP_ARRAY_ERASE_A    8'h60
`define OP_QUAD_OUT         8'h6B
`define OP_QUAD_OUT_L       8'h6C
`define OP_LEGACY_SIG       8'h90
`define OP_ID_READ          8'h9F
`define OP_PERF_MODE        8'hA3
`define OP_BANK_ACCESS      8'hB9
`define OP_DUAL_IO          8'hBB
`define OP_DUAL_IO_L        8'hBC
`define OP_DDR_DUAL_IO      8'hBD
`define OP_DDR_DUAL_IO_L    8'hBE
`define OP_ARRAY_ERASE_B    8'hC7
`define OP_SECTOR_ERASE     8'hD8
`define OP_SECTOR_ERASE_L   8'hDC
`define OP_RESERVED_E5      8'hE5
`define OP_RESERVED_E6      8'hE6
`define OP_QUAD_IO          8'hEB
`define OP_QUAD_IO_L        8'hEC
`define OP_DDR_QUAD_IO      8'hED
`define OP_DDR_QUAD_IO_L    8'hEE
`define OP_SOFT_RESET       8'hF0
`define OP_MODE_EXIT        8'hFF

// Lane counts
`define LANE1               3'h1
`define LANE2               3'h2
`define LANE4               3'h4

// Clock limits in MHz (50, 80, 104, 133)
`define MHZ_50              8'h32
`define MHZ_80              8'h50
`define MHZ_104             8'h68
`define MHZ_133             8'h85

// Byte width and address lengths
`define BYTE_BITS           4'h8
`define ADDR_BYTES_SHORT    3'h3
`define ADDR_BYTES_LONG     3'h4

`endif

// [verification/flash_host_checker.sv]
// Port assertions for the serial flash host
`timescale 1ns/1ps
module flash_host_checker #(
  parameter SCK_HALF = 1
) (
  input wire       core_clk,
  input wire       reset,
  input wire       cmdValid,
  input wire       cmdReady,
  input wire [7:0] cmdOpcode,
  input wire       cmdError,
  input wire       cmdDone,
  input wire       serialClock,
  input wire       chipSelectN,
  input wire [3:0] dataLineOut,
  input wire [3:0] dataLineOe
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  wire take = cmdValid && cmdReady;
  wire bad  = cmdOpcode inside {8'hA3, 8'hE5, 8'hE6};
  wire ddr  = cmdOpcode inside {8'h0D, 8'h0E, 8'hBD, 8'hBE, 8'hED, 8'hEE};
  reg  exitFrame;
  // Marks a frame carrying the read mode exit opcode
  always @(posedge core_clk) begin
    if (reset || cmdDone)
      exitFrame <= 1'b0;
    else if (take && cmdOpcode == 8'hFF)
      exitFrame <= 1'b1;
  end
  a_reserved_refused: assert property (take && bad |-> ##[1:2] cmdError)
    else $error("reserved opcode not refused");
  a_ddr_refused: assert property (take && ddr |-> ##[1:2] cmdError)
    else $error("double rate opcode not refused");
  a_refused_silent: assert property (cmdError |-> chipSelectN && !serialClock)
    else $error("refused command reached the pins");
  a_legal_starts: assert property (take && !bad && !ddr |-> ##[1:2] !chipSelectN)
    else $error("accepted command opened no frame");
  a_clock_idle: assert property (chipSelectN |-> !serialClock)
    else $error("serial clock not idle low");
  a_done_at_end: assert property (cmdDone |-> chipSelectN && $past(!chipSelectN))
    else $error("done not at chip select rise");
  a_busy_not_ready: assert property (!chipSelectN |-> !cmdReady)
    else $error("ready during a frame");
  a_exit_ones: assert property (exitFrame && !chipSelectN |-> dataLineOut[0] && dataLineOe[0])
    else $error("exit frame line 0 not driven high");
endmodule

// [verification/flash_model.sv]
// Behavioural serial flash facing the host
`timescale 1ns/1ps
module flash_model #(
  parameter [7:0] ID_BYTE = 8'h5C // Arbitrary identification value
) (
  input  wire       serialClock,
  input  wire       chipSelectN,
  input  wire [3:0] dataLineOut,
  input  wire [3:0] dataLineOe,
  output wire [3:0] dataLineIn
);
  logic [7:0]  opcode   = 8'h00;
  logic [31:0] shiftReg = 32'h0000_0000;
  logic [31:0] bitCount = 32'h0000_0000;
  logic [31:0] frames   = 32'h0000_0000;
  logic [31:0] nvWrites = 32'h0000_0000;
  logic        devBit   = 1'b0;
  logic [3:0]  devNib   = 4'h0;
  // Quad output read answers on all four lines once opcode and address are in
  wire         quadOut  = (opcode == 8'h6B) && (bitCount >= 32);
  // Released lines show a changing pattern, host lines pass through
  assign dataLineIn = (dataLineOe & dataLineOut) |
                      (~dataLineOe & (quadOut ? devNib : {~devBit, devBit, devBit, ~devBit}));
  // Frame opens
  always @(negedge chipSelectN) begin
    frames <= frames + 1;
    bitCount <= 32'h0000_0000;
  end
  // Opcode and data captured on rising edges
  always @(posedge serialClock) begin
    if (!chipSelectN) begin
      if (bitCount < 8)
        opcode <= {opcode[6:0], dataLineIn[0]};
      shiftReg <= {shiftReg[30:0], dataLineIn[0]};
      bitCount <= bitCount + 1;
    end
  end
  // Command acts at chip select rise; register writes wear the array
  always @(posedge chipSelectN) begin
    if (opcode == 8'h01 || opcode == 8'h43)
      nvWrites <= nvWrites + 1;
  end
  // Identification read answers on line 1, quad read with the inverted byte
  always @(negedge serialClock or posedge chipSelectN) begin
    if (!chipSelectN && opcode == 8'h9F && bitCount >= 8)
      devBit <= ID_BYTE[~bitCount[2:0]];
    else
      devBit <= ~devBit;
    devNib <= bitCount[0] ? ~ID_BYTE[3:0] : ~ID_BYTE[7:4];
  end
endmodule

// [verification/flash_host_bench.sv]
// Self-checking bench for the serial flash host
`timescale 1ns/1ps
module flash_host_bench;
  localparam logic [7:0] ID_CODE = 8'h5C; // Arbitrary identification value
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  logic        cmdValid = 1'b0;
  logic [7:0]  cmdOpcode = 8'h00;
  logic [31:0] cmdAddr = 32'h0000_0000;
  logic [2:0]  cmdAddrBytes = 3'h0;
  logic [15:0] cmdWriteCount = 16'h0000;
  logic [15:0] cmdReadCount = 16'h0000;
  logic        txValid = 1'b0;
  logic [7:0]  lastRx = 8'h00;
  wire         cmdReady, cmdError, cmdDone, txReady, rxValid, serialClock, chipSelectN;
  wire [7:0]   rxData;
  wire [3:0]   dataLineOut, dataLineOe, dataLineIn;
  int          fails = 0;
  int          checks = 0;
  int          cycles = 0;
  int          lowCnt = 0;
  int          txTaken = 0;
  logic [7:0]  badOps [0:8] = '{8'hA3, 8'hE5, 8'hE6, 8'h0D, 8'h0E, 8'hBD, 8'hBE, 8'hED, 8'hEE};
  logic [7:0]  okOps [0:31] = '{8'h01, 8'h02, 8'h03, 8'h0B, 8'h0C, 8'h12, 8'h13, 8'h20,
    8'h21, 8'h30, 8'h32, 8'h34, 8'h38, 8'h3B, 8'h3C, 8'h43, 8'h4A, 8'h60, 8'h6B, 8'h6C,
    8'h90, 8'h9F, 8'hB9, 8'hBB, 8'hBC, 8'hC7, 8'hD8, 8'hDC, 8'hEB, 8'hEC, 8'hF0, 8'hFF};

  flash_host flash_host_i (.core_clk(core_clk), .reset(reset), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .cmdOpcode(cmdOpcode), .cmdAddr(cmdAddr),
    .cmdAddrBytes(cmdAddrBytes), .cmdDummy(8'h00), .cmdWriteCount(cmdWriteCount),
    .cmdReadCount(cmdReadCount), .cmdError(cmdError), .cmdDone(cmdDone), .txData(8'hA5),
    .txValid(txValid), .txReady(txReady), .rxData(rxData), .rxValid(rxValid),
    .serialClock(serialClock), .chipSelectN(chipSelectN), .dataLineOut(dataLineOut),
    .dataLineOe(dataLineOe), .dataLineIn(dataLineIn));
  flash_model #(.ID_BYTE(ID_CODE)) flash_model_i (.serialClock(serialClock),
    .chipSelectN(chipSelectN), .dataLineOut(dataLineOut), .dataLineOe(dataLineOe),
    .dataLineIn(dataLineIn));

  // Clock, timeout, late write data and read capture
  initial forever #25 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (rxValid === 1'b1)
      lastRx <= rxData;
    if (txReady === 1'b1)
      txTaken <= txTaken + 1;
    if (cycles == 6000) begin
      fails = fails + 1;
      end_sim();
    end
  end
  always @(negedge core_clk) begin
    lowCnt <= (chipSelectN === 1'b0) ? lowCnt + 1 : 0;
    txValid <= (lowCnt > 120); // Stalls the frame before the data byte
  end

  task end_sim;
    if (fails == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input [31:0] got, input [31:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One command: taken at the next rising edge, then wait for its outcome
  task automatic send(input [7:0] op, input [2:0] ab, input [31:0] ad, input [15:0] wc,
                      input [15:0] rc);
    int n;
    @(negedge core_clk);
    cmdOpcode = op;
    cmdAddrBytes = ab;
    cmdAddr = ad;
    cmdWriteCount = wc;
    cmdReadCount = rc;
    cmdValid = 1'b1;
    n = 0;
    do begin
      @(negedge core_clk);
      cmdValid = 1'b0;
      n = n + 1;
    end while (cmdError !== 1'b1 && cmdDone !== 1'b1 && n < 2000);
  endtask

  task automatic t_refuse;
    logic [31:0] f;
    for (int i = 0; i < 9; i++) begin
      f = flash_model_i.frames;
      send(badOps[i], 3'h0, 32'h0, 16'h0, 16'h0);
      chk({31'h0, cmdError}, 32'h1);
      chk(flash_model_i.frames, f);
    end
  endtask

  task automatic t_opcodes;
    for (int i = 0; i < 32; i++) begin
      send(okOps[i], 3'h0, 32'h0, 16'h0, 16'h0);
      chk({31'h0, cmdDone}, 32'h1);
      chk({24'h0, flash_model_i.opcode}, {24'h0, okOps[i]});
    end
    chk(flash_model_i.nvWrites, 32'h2);
  endtask

  initial begin
    repeat (4) @(negedge core_clk);
    reset = 1'b0;
    t_refuse();
    t_opcodes();
    send(8'h9F, 3'h0, 32'h0, 16'h0, 16'h1);
    chk({24'h0, lastRx}, {24'h0, ID_CODE});
    send(8'h02, 3'h3, 32'h0012_3456, 16'h1, 16'h0);
    chk(flash_model_i.shiftReg, 32'h1234_56A5);
    chk(txTaken, 32'h1);
    send(8'h6B, 3'h3, 32'h0000_0100, 16'h0, 16'h1);
    chk({24'h0, lastRx}, {24'h0, ~ID_CODE});
    end_sim();
  end
endmodule

bind flash_host flash_host_checker #(.SCK_HALF(SCK_HALF)) flash_host_checker_i (
  .core_clk(core_clk), .reset(reset), .cmdValid(cmdValid), .cmdReady(cmdReady),
  .cmdOpcode(cmdOpcode), .cmdError(cmdError), .cmdDone(cmdDone),
  .serialClock(serialClock), .chipSelectN(chipSelectN), .dataLineOut(dataLineOut),
  .dataLineOe(dataLineOe));
